// ---- shared/link_ctrl_pkg.sv ----
// Constants and types shared by the link fault and misc control block.
// Assumes an upstream serial control engine that delivers byte-wide
// register reads and writes as one-cycle strobes on the system clock.
package link_ctrl_pkg;

    // Register offsets
    localparam logic [7:0] OFS_FAULT_POLICY = 8'hB9;
    localparam logic [7:0] OFS_ENC_CHECK    = 8'hBA;
    localparam logic [7:0] OFS_SPARE_BB     = 8'hBB;
    localparam logic [7:0] OFS_FRAME_MIN    = 8'hBC;
    localparam logic [7:0] OFS_SPARE_BD     = 8'hBD;
    localparam logic [7:0] OFS_PULLDOWN     = 8'hBE;
    localparam logic [7:0] OFS_SPARE_BF     = 8'hBF;

    // Field widths and positions
    localparam int         LIMIT_W          = 4;
    localparam int         PIN_COUNT        = 7;
    localparam int         POS_ENC_DISABLE  = 7;

    // Values after reset
    localparam logic       RST_FILTER_WAIT  = 1'h1;
    localparam logic       RST_COUNT_EN     = 1'h1;
    localparam logic [3:0] RST_LIMIT        = 4'h3;
    localparam logic       RST_ENC_DISABLE  = 1'h0;
    localparam logic [6:0] RST_ENC_SPARE    = 7'h03;
    localparam logic [7:0] RST_SPARE_BB     = 8'h74;
    localparam logic [7:0] RST_FRAME_MIN    = 8'h80;
    localparam logic [7:0] RST_SPARE_BD     = 8'h00;
    localparam logic [6:0] RST_PULLDOWN_OFF = 7'h00;
    localparam logic [7:0] RST_SPARE_BF     = 8'h00;
    localparam logic [7:0] RST_LINK_INFO    = 8'h00;

    // Fault policy register layout
    typedef struct packed {
        logic [1:0]         spare;
        logic               filter_wait_error_ignore;
        logic               count_en;
        logic [LIMIT_W-1:0] link_fault_limit;
    } fault_policy_t;

    // Register request from the control bus engine
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Signals arriving from the forward-channel receiver, not yet synchronised
    typedef struct packed {
        logic       pix_clk;
        logic       parity_err;
        logic       clock_err;
        logic       control_err;
        logic       sampling_filter_wait;
        logic       lock_acquire;
        logic       frame_active;
        logic       info_valid;
        logic       info_crc_ok;
        logic [7:0] info_data;
    } link_in_t;

endpackage

// ---- core/link_sync.sv ----
// Two-stage synchroniser for a bundle of level signals.
// Assumes each bit is held long enough to be seen by the system clock.
`timescale 1ns/1ps
`default_nettype none
module link_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    // First stage feeds only the second stage
    always_comb begin
        s_d      = s_q;
        s_d.meta = d;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.sync;
endmodule
`default_nettype wire

// ---- core/frame_start_gate.sv ----
// Frame-start generator for raw input mode.
// Assumes tick marks one forward-link clock period and frame_active is synchronised.
`timescale 1ns/1ps
`default_nettype none
module frame_start_gate (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Link side
    input  wire logic       tick,
    input  wire logic       frame_active,
    input  wire logic       raw_mode,
    input  wire logic [7:0] min_span,
    // Event
    output logic            frame_start
);
    typedef struct packed {
        logic [7:0] span;
        logic       sent;
        logic       fs;
    } gate_state_t;

    gate_state_t g_q;
    gate_state_t g_d;
    logic [7:0]  span_inc;

    // Saturate so very long frames never wrap and fire twice
    assign span_inc = (g_q.span == 8'hFF) ? 8'hFF : g_q.span + 8'h01;

    // Count link periods of frame_active, fire once per frame
    always_comb begin
        g_d    = g_q;
        g_d.fs = 1'b0;
        if (!frame_active || !raw_mode) begin
            g_d.span = 8'h00;
            g_d.sent = 1'b0;
        end else if (tick) begin
            g_d.span = span_inc;
            if (!g_q.sent && span_inc >= min_span) begin
                g_d.fs   = 1'b1;
                g_d.sent = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            g_q <= '0;
        end else begin
            g_q <= g_d;
        end
    end

    assign frame_start = g_q.fs;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_fs_after_span;
        frame_start |-> $past(raw_mode) && $past(frame_active) && g_q.span >= $past(min_span);
    endproperty
    a_fs_after_span: assert property (p_fs_after_span)
        else $error("frame start before minimum span");

    property p_fs_once;
        frame_start |=> !frame_start;
    endproperty
    a_fs_once: assert property (p_fs_once)
        else $error("frame start repeated");
endmodule
`default_nettype wire

// ---- core/link_fault_control.sv ----
// Link fault policy, encoder check, frame-start gate and pulldown control.
// Assumes register strobes from the control bus engine on CLK_SYS and
// forward-channel signals from the receiver in its own clock domain.
// Behaviour
// - Link errors are counted only while the count enable bit is set; resets set.
// - With counting on, lock drops when the error count reaches the 4-bit limit.
// - With counting off, the first link error drops lock.
// - The error counter advances only on recovered pixel clock edges.
// - Parity, embedded clock and control bit failures all count as link errors.
// - When set, errors during the sampling filter wait are ignored; resets set.
// - Bit 7 disables the encoder CRC; with CRC on, failing packets update nothing.
// - Raw mode frame start comes only after frame_active held the set periods.
// - A pin's pulldown is on whenever the pin is neither an output nor forced off.
// - Seven pulldown-off bits force each pin's pulldown off when set; reset clear.
`timescale 1ns/1ps
`default_nettype none
module link_fault_control (
    // Clock and reset
    input  wire logic                               CLK_SYS,
    input  wire logic                               RESET,
    // Register access
    input  wire link_ctrl_pkg::reg_req_t            REG_REQ,
    output logic      [7:0]                         REG_RDATA,
    output logic                                    REG_RVALID,
    // Forward channel receiver
    input  wire link_ctrl_pkg::link_in_t            LINK_IN,
    input  wire logic                               RAW_MODE,
    output logic                                    LOCK,
    output logic      [link_ctrl_pkg::LIMIT_W-1:0]  ERR_COUNT,
    output logic      [7:0]                         LINK_INFO,
    output logic                                    FRAME_START,
    // Pin pads
    input  wire logic [link_ctrl_pkg::PIN_COUNT-1:0] PIN_OUT_MODE,
    output logic      [link_ctrl_pkg::PIN_COUNT-1:0] PULLDOWN_EN
);
    import link_ctrl_pkg::*;

    typedef struct packed {
        fault_policy_t          policy;
        logic                   enc_disable;
        logic [6:0]             enc_spare;
        logic [7:0]             spare_bb;
        logic [7:0]             frame_min;
        logic [7:0]             spare_bd;
        logic [PIN_COUNT-1:0]   pd_off;
        logic [7:0]             spare_bf;
        logic                   locked;
        logic [LIMIT_W-1:0]     err_cnt;
        logic                   tick_prev;
        logic                   acq_prev;
        logic                   info_prev;
        logic [7:0]             link_info;
        logic [PIN_COUNT-1:0]   pd_en;
        logic [7:0]             rdata;
        logic                   rvalid;
    } core_state_t;

    localparam core_state_t CORE_RESET = '{
        policy:      '{spare: 2'h0, filter_wait_error_ignore: RST_FILTER_WAIT,
                       count_en: RST_COUNT_EN, link_fault_limit: RST_LIMIT},
        enc_disable: RST_ENC_DISABLE,
        enc_spare:   RST_ENC_SPARE,
        spare_bb:    RST_SPARE_BB,
        frame_min:   RST_FRAME_MIN,
        spare_bd:    RST_SPARE_BD,
        pd_off:      RST_PULLDOWN_OFF,
        spare_bf:    RST_SPARE_BF,
        locked:      1'b0,
        err_cnt:     '0,
        tick_prev:   1'b0,
        acq_prev:    1'b0,
        info_prev:   1'b0,
        link_info:   RST_LINK_INFO,
        pd_en:       {PIN_COUNT{1'b1}},
        rdata:       8'h00,
        rvalid:      1'b0
    };

    core_state_t q;
    core_state_t d;
    link_in_t    lk;
    logic        tick;
    logic        acq_rise;
    logic        info_rise;
    logic        any_err;
    logic        ignore_err;
    logic        err_evt;
    logic [LIMIT_W-1:0] cnt_inc;
    logic        fs;

    // Register read decode; unmapped offsets read as zero
    function automatic logic [7:0] read_value(input core_state_t s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            OFS_FAULT_POLICY: v = {2'b00, s.policy.filter_wait_error_ignore,
                                   s.policy.count_en, s.policy.link_fault_limit};
            OFS_ENC_CHECK:    v = {s.enc_disable, s.enc_spare};
            OFS_SPARE_BB:     v = s.spare_bb;
            OFS_FRAME_MIN:    v = s.frame_min;
            OFS_SPARE_BD:     v = s.spare_bd;
            OFS_PULLDOWN:     v = {1'b0, s.pd_off};
            OFS_SPARE_BF:     v = s.spare_bf;
            default:          v = 8'h00;
        endcase
        return v;
    endfunction

    // Every receiver signal crosses into CLK_SYS before anything reads it
    link_sync #(.W($bits(link_in_t))) u_sync (
        .clk   (CLK_SYS),
        .reset (RESET),
        .d     (LINK_IN),
        .q     (lk)
    );

    // Pixel clock edges become one-cycle ticks; the error counter steps only on them
    assign tick      = lk.pix_clk && !q.tick_prev;
    assign acq_rise  = lk.lock_acquire && !q.acq_prev;
    assign info_rise = lk.info_valid && !q.info_prev;
    assign any_err   = lk.parity_err || lk.clock_err || lk.control_err;
    assign ignore_err = q.policy.filter_wait_error_ignore && lk.sampling_filter_wait;
    assign err_evt   = tick && any_err && !ignore_err;
    assign cnt_inc   = (q.err_cnt == {LIMIT_W{1'b1}}) ? q.err_cnt : q.err_cnt + 4'h1;

    always_comb begin
        d        = q;
        d.rvalid = 1'b0;
        // Register writes; read-only spare bits are not stored
        if (REG_REQ.wr) begin
            case (REG_REQ.addr)
                OFS_FAULT_POLICY: d.policy = fault_policy_t'({2'b00, REG_REQ.wdata[5:0]});
                OFS_ENC_CHECK: begin
                    d.enc_disable = REG_REQ.wdata[POS_ENC_DISABLE];
                    d.enc_spare   = REG_REQ.wdata[6:0];
                end
                OFS_SPARE_BB:  d.spare_bb  = REG_REQ.wdata;
                OFS_FRAME_MIN: d.frame_min = REG_REQ.wdata;
                OFS_SPARE_BD:  d.spare_bd  = REG_REQ.wdata;
                OFS_PULLDOWN:  d.pd_off    = REG_REQ.wdata[PIN_COUNT-1:0];
                OFS_SPARE_BF:  d.spare_bf  = REG_REQ.wdata;
                default: ;
            endcase
        end
        // Reads see the state before a same-cycle write
        if (REG_REQ.rd) begin
            d.rdata  = read_value(q, REG_REQ.addr);
            d.rvalid = 1'b1;
        end
        // Edge history for the synchronised receiver signals
        d.tick_prev = lk.pix_clk;
        d.acq_prev  = lk.lock_acquire;
        d.info_prev = lk.info_valid;
        // Lock supervision
        if (q.locked) begin
            if (!lk.lock_acquire) begin
                d.locked  = 1'b0;
                d.err_cnt = '0;
            end else if (err_evt) begin
                if (!q.policy.count_en) begin
                    d.locked  = 1'b0;
                    d.err_cnt = '0;
                end else if (cnt_inc >= q.policy.link_fault_limit) begin
                    d.locked  = 1'b0;
                    d.err_cnt = '0;
                end else begin
                    d.err_cnt = cnt_inc;
                end
            end else if (!q.policy.count_en) begin
                d.err_cnt = '0;
            end
        end else begin
            // Count starts fresh for the next lock period
            d.err_cnt = '0;
            if (acq_rise) begin
                d.locked = 1'b1;
            end
        end
        // Link information update gated by the encoder CRC result
        if (info_rise && (lk.info_crc_ok || q.enc_disable)) begin
            d.link_info = lk.info_data;
        end
        // Pulldown on unless pin drives or software forces it off
        d.pd_en = ~(PIN_OUT_MODE | q.pd_off);
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            q <= CORE_RESET;
        end else begin
            q <= d;
        end
    end

    // Raw mode frame start gate on the synchronised frame_active
    frame_start_gate u_fs (
        .clk          (CLK_SYS),
        .reset        (RESET),
        .tick         (tick),
        .frame_active (lk.frame_active),
        .raw_mode     (RAW_MODE),
        .min_span     (q.frame_min),
        .frame_start  (fs)
    );

    // Outputs straight from flip-flops
    assign LOCK        = q.locked;
    assign ERR_COUNT   = q.err_cnt;
    assign LINK_INFO   = q.link_info;
    assign FRAME_START = fs;
    assign PULLDOWN_EN = q.pd_en;
    assign REG_RDATA   = q.rdata;
    assign REG_RVALID  = q.rvalid;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    sequence s_err_while_locked;
        q.locked && lk.lock_acquire && err_evt;
    endsequence

    property p_no_count_when_off;
        q.locked && !q.policy.count_en |=> ERR_COUNT == '0;
    endproperty
    a_no_count_when_off: assert property (p_no_count_when_off)
        else $error("error counter moved while counting disabled");

    property p_drop_at_limit;
        s_err_while_locked ##0 (q.policy.count_en && cnt_inc >= q.policy.link_fault_limit)
            |=> !LOCK && ERR_COUNT == '0;
    endproperty
    a_drop_at_limit: assert property (p_drop_at_limit)
        else $error("lock held after error limit reached");

    property p_count_below_limit;
        s_err_while_locked ##0 (q.policy.count_en && cnt_inc < q.policy.link_fault_limit)
            |=> LOCK && ERR_COUNT == $past(cnt_inc);
    endproperty
    a_count_below_limit: assert property (p_count_below_limit)
        else $error("error below limit mishandled");

    property p_drop_first_error;
        s_err_while_locked ##0 !q.policy.count_en |=> !LOCK;
    endproperty
    a_drop_first_error: assert property (p_drop_first_error)
        else $error("lock held after first error with counting off");

    property p_count_on_tick;
        q.locked && lk.lock_acquire && q.policy.count_en && !tick |=> $stable(ERR_COUNT) && LOCK;
    endproperty
    a_count_on_tick: assert property (p_count_on_tick)
        else $error("error counter moved without pixel clock edge");

    property p_filter_wait_ignored;
        q.locked && lk.lock_acquire && q.policy.count_en && tick && ignore_err
            |=> LOCK && $stable(ERR_COUNT);
    endproperty
    a_filter_wait_ignored: assert property (p_filter_wait_ignored)
        else $error("error during filter wait not ignored");

    property p_crc_blocks_update;
        info_rise && !lk.info_crc_ok && !q.enc_disable |=> $stable(LINK_INFO);
    endproperty
    a_crc_blocks_update: assert property (p_crc_blocks_update)
        else $error("link info updated from failing packet");

    property p_pulldown;
        ##1 PULLDOWN_EN == ~($past(PIN_OUT_MODE) | $past(q.pd_off));
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("pulldown enable wrong");

    property p_clear_on_lock_change;
        $changed(LOCK) |-> ERR_COUNT == '0;
    endproperty
    a_clear_on_lock_change: assert property (p_clear_on_lock_change)
        else $error("error counter not cleared on lock change");

    // A rising lock_acquire while unlocked relocks with a clean count
    property p_lock_on_acquire;
        !q.locked && acq_rise |=> LOCK && ERR_COUNT == '0;
    endproperty
    a_lock_on_acquire: assert property (p_lock_on_acquire)
        else $error("lock not taken on acquire edge");

    // Receiver losing lock always drops ours and wipes the count
    property p_drop_on_loss;
        q.locked && !lk.lock_acquire |=> !LOCK && ERR_COUNT == '0;
    endproperty
    a_drop_on_loss: assert property (p_drop_on_loss)
        else $error("lock held after receiver lost lock");

    // Errors seen while unlocked never leave a count behind
    property p_idle_count_clear;
        !q.locked |=> ERR_COUNT == '0;
    endproperty
    a_idle_count_clear: assert property (p_idle_count_clear)
        else $error("error count held while unlocked");

    // A packet that passes, or arrives with the check off, is taken
    property p_crc_pass_updates;
        info_rise && (lk.info_crc_ok || q.enc_disable) |=> LINK_INFO == $past(lk.info_data);
    endproperty
    a_crc_pass_updates: assert property (p_crc_pass_updates)
        else $error("link info not taken from good packet");
endmodule
`default_nettype wire

// ---- tb/fwd_rx_model.sv ----
// Behavioural forward-channel receiver that feeds the link fault block.
// Assumes the bench drives req on CLK_SYS; pix_clk is made here, 8 CLK_SYS periods long.
`timescale 1ns/1ps
`default_nettype none
module fwd_rx_model (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // Bench commands
    input  wire logic                    run,
    input  wire link_ctrl_pkg::link_in_t req,
    // Receiver outputs
    output var link_ctrl_pkg::link_in_t  link
);
    import link_ctrl_pkg::*;

    logic [2:0] cnt_q;
    link_in_t   link_d;

    // Pixel clock stands still while run is low
    // Errors change only as pix_clk falls, so each one spans whole pixel periods, one rising edge per period held
    always_comb begin
        link_d         = req;
        link_d.pix_clk = run && (cnt_q inside {3'h3, 3'h4, 3'h5, 3'h6});
        if (cnt_q != 3'h7) begin
            link_d.parity_err  = link.parity_err;
            link_d.clock_err   = link.clock_err;
            link_d.control_err = link.control_err;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 3'h0;
            link  <= '0;
        end else begin
            cnt_q <= run ? cnt_q + 3'h1 : cnt_q;
            link  <= link_d;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the link fault and misc control block.
// Assumes the package, design files and the receiver model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
    import link_ctrl_pkg::*;

    logic       clk_sys;
    logic       reset;
    reg_req_t   reg_req;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    link_in_t   cmd;
    link_in_t   lnk;
    logic       run;
    logic       raw_mode;
    logic       lock;
    logic [3:0] err_count;
    logic [7:0] link_info;
    logic       frame_start;
    logic [6:0] pin_out_mode;
    logic [6:0] pulldown_en;
    int         err_total = 0;
    int         compares  = 0;
    int         cyc       = 0;

    // Device and far side
    link_fault_control dut (
        .CLK_SYS      (clk_sys),
        .RESET        (reset),
        .REG_REQ      (reg_req),
        .REG_RDATA    (reg_rdata),
        .REG_RVALID   (reg_rvalid),
        .LINK_IN      (lnk),
        .RAW_MODE     (raw_mode),
        .LOCK         (lock),
        .ERR_COUNT    (err_count),
        .LINK_INFO    (link_info),
        .FRAME_START  (frame_start),
        .PIN_OUT_MODE (pin_out_mode),
        .PULLDOWN_EN  (pulldown_en)
    );
    fwd_rx_model rx_mdl (
        .clk   (clk_sys),
        .reset (reset),
        .run   (run),
        .req   (cmd),
        .link  (lnk)
    );

    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;

    // Hang guard; the full run needs well under 3000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            print_verdict;
        end
    end

    task automatic print_verdict;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask

    // Read answer is a one-cycle pulse, so it is judged in that cycle
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        #1;
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, e)
    endtask

    // Errors of one kind over n whole pixel periods; 0 parity, 1 clock, 2 control
    task automatic send_err(input int kind, input int n);
        @(posedge lnk.pix_clk);
        @(posedge clk_sys);
        cmd.parity_err  <= (kind == 0);
        cmd.clock_err   <= (kind == 1);
        cmd.control_err <= (kind == 2);
        @(negedge lnk.pix_clk);
        repeat (n) @(posedge lnk.pix_clk);
        @(posedge clk_sys);
        {cmd.parity_err, cmd.clock_err, cmd.control_err} <= 3'h0;
        idle(8);
    endtask

    // Relock needs lock_acquire to fall and rise again
    task automatic relock;
        @(posedge clk_sys);
        cmd.lock_acquire <= 1'b0;
        idle(6);
        cmd.lock_acquire <= 1'b1;
        idle(6);
        `CHK(lock, 1'b1)
    endtask

    task automatic send_info(input logic [7:0] d, input logic ok);
        @(posedge clk_sys);
        cmd.info_data   <= d;
        cmd.info_crc_ok <= ok;
        cmd.info_valid  <= 1'b1;
        idle(6);
        cmd.info_valid  <= 1'b0;
        idle(6);
    endtask

    task automatic t_reset;
        `CHK(pulldown_en, ~pin_out_mode)
        reg_chk(OFS_FAULT_POLICY, 8'h33);
        reg_chk(OFS_ENC_CHECK, 8'h03);
        reg_chk(OFS_SPARE_BB, 8'h74);
        reg_chk(OFS_FRAME_MIN, 8'h80);
        reg_chk(OFS_SPARE_BD, 8'h00);
        reg_chk(OFS_PULLDOWN, 8'h00);
        reg_chk(OFS_SPARE_BF, 8'h00);
        reg_chk(8'hC0, 8'h00);
    endtask

    task automatic t_regs;
        for (logic [7:0] a = 8'hB9; a <= 8'hBF; a++) begin
            reg_wr(a, 8'hFF);
        end
        reg_wr(8'hB8, 8'hFF);
        reg_chk(8'hB8, 8'h00);
        reg_chk(OFS_FAULT_POLICY, 8'h3F);
        reg_chk(OFS_ENC_CHECK, 8'hFF);
        reg_chk(OFS_FRAME_MIN, 8'hFF);
        reg_chk(OFS_PULLDOWN, 8'h7F);
        `CHK(pulldown_en, 7'h00)
        @(posedge clk_sys);
        pin_out_mode <= 7'h55;
        reg_wr(OFS_PULLDOWN, 8'h0F);
        idle(2);
        `CHK(pulldown_en, 7'h20)
        reg_wr(OFS_PULLDOWN, 8'h00);
        reg_wr(OFS_ENC_CHECK, 8'h03);
    endtask

    task automatic t_count;
        reg_wr(OFS_FAULT_POLICY, 8'h13);
        relock;
        send_err(0, 1);
        send_err(1, 1);
        `CHK(err_count, 4'h2)
        `CHK(lock, 1'b1)
        send_err(2, 1);
        `CHK(lock, 1'b0)
        `CHK(err_count, 4'h0)
        reg_wr(OFS_FAULT_POLICY, 8'h15);
        relock;
        send_err(0, 4);
        `CHK(err_count, 4'h4)
        `CHK(lock, 1'b1)
        send_err(0, 1);
        `CHK(lock, 1'b0)
        reg_wr(OFS_FAULT_POLICY, 8'h03);
        relock;
        `CHK(err_count, 4'h0)
        send_err(1, 1);
        `CHK(lock, 1'b0)
        `CHK(err_count, 4'h0)
    endtask

    task automatic t_filter;
        reg_wr(OFS_FAULT_POLICY, 8'h33);
        relock;
        cmd.sampling_filter_wait <= 1'b1;
        send_err(0, 3);
        `CHK(lock, 1'b1)
        `CHK(err_count, 4'h0)
        reg_wr(OFS_FAULT_POLICY, 8'h13);
        send_err(0, 3);
        `CHK(lock, 1'b0)
        cmd.sampling_filter_wait <= 1'b0;
    endtask

    task automatic t_info;
        send_info(8'hA5, 1'b0);
        `CHK(link_info, 8'h00)
        send_info(8'h5A, 1'b1);
        `CHK(link_info, 8'h5A)
        reg_wr(OFS_ENC_CHECK, 8'h83);
        send_info(8'hC3, 1'b0);
        `CHK(link_info, 8'hC3)
    endtask

    // Counts pixel ticks since frame_active rose, counts pulses and keeps the tick of the last one
    task automatic t_frame(input logic raw, input int exp_at, input int exp_n);
        int ticks;
        int at;
        int pulses;
        logic hi;
        ticks = 0;
        at = -1;
        pulses = 0;
        hi = 1'b0;
        @(negedge lnk.pix_clk);
        @(posedge clk_sys);
        raw_mode <= raw;
        cmd.frame_active <= 1'b1;
        repeat (80) begin
            @(posedge clk_sys);
            #1;
            if (lnk.pix_clk === 1'b1 && !hi) ticks++;
            hi = lnk.pix_clk;
            if (frame_start === 1'b1) begin
                pulses++;
                at = ticks;
            end
        end
        `CHK(pulses, exp_n)
        `CHK(at, exp_at)
        @(posedge clk_sys);
        cmd.frame_active <= 1'b0;
        raw_mode <= 1'b0;
        idle(4);
    endtask

    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        reg_req = '0;
        cmd = '0;
        run = 1'b0;
        raw_mode = 1'b0;
        pin_out_mode = 7'h00;
        idle(12);
        reset <= 1'b0;
        run <= 1'b1;
        idle(4);
        t_reset;
        t_regs;
        t_count;
        t_filter;
        t_info;
        reg_wr(OFS_FRAME_MIN, 8'h04);
        t_frame(1'b1, 4, 1);
        t_frame(1'b0, -1, 0);
        print_verdict;
    end
endmodule
`default_nettype wire
